// >>> core/flash_cmd_cfg.svh
// Purpose: constants for the flash command host, byte-wide bus mode
// Assumes: 200 MHz core clock, flash in byte mode (24-bit byte address)
// Notes: times in ns, cycle counts derived by rounding up
// Function
// - host suspends erase with one bank write
// - host leaves query modes before resume
// - host never enters extra block, so issues no exit before resume
// - on error host issues read/reset
// - byte program AAA/AA,555/55,AAA/A0,target/value
// - chip erase six writes ending AAA/10
// - block erase sixth write BAd/30, repeatable
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH

`define CLK_PERIOD_PS 5000
`define CYC_UP(ns) ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`define T_ADDR_SETUP_NS 10
`define T_WE_LOW_NS 35
`define T_WE_HIGH_NS 30
`define T_READ_ACC_NS 70
`define T_READ_REC_NS 30

`define ADDR_W 24
`define DATA_W 8
`define BANK_LSB 12

`define UNLOCK1_ADDR 12'hAAA
`define UNLOCK2_ADDR 12'h555
`define CODE_UNLOCK1 8'hAA
`define CODE_UNLOCK2 8'h55
`define CODE_PROGRAM 8'hA0
`define CODE_ERASE_SETUP 8'h80
`define CODE_CHIP_ERASE 8'h10
`define CODE_BLOCK_ERASE 8'h30
`define CODE_SUSPEND 8'hB0
`define CODE_RESUME 8'h30
`define CODE_AUTO_SELECT 8'h90
`define CODE_CFI_QUERY 8'h98
`define CODE_READ_RESET 8'hF0

`define DATA_POLL_BIT 7
`define TOGGLE_BIT 6
`define POLL_LIMIT_DEFAULT 100000

`endif

// >>> core/flash_cmd_pkg.sv
// Purpose: types shared by the flash command host
// Assumes: nothing beyond the cfg header
// Notes: command codes are the user-port encoding, not flash codes
package flash_cmd_pkg;
  typedef enum logic [3:0] {
    CMD_READ_RESET = 4'h0,
    CMD_AUTO_SELECT = 4'h1,
    CMD_PROGRAM = 4'h2,
    CMD_CHIP_ERASE = 4'h3,
    CMD_BLOCK_ERASE = 4'h4,
    CMD_BLOCK_ADD = 4'h5,
    CMD_SUSPEND = 4'h6,
    CMD_RESUME = 4'h7,
    CMD_CFI_QUERY = 4'h8,
    CMD_READ = 4'h9,
    CMD_POLL = 4'hA
  } host_cmd_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_LOOK = 4'h1,
    ST_SETUP = 4'h2,
    ST_WE_LOW = 4'h3,
    ST_WE_HIGH = 4'h4,
    ST_RD_LOW = 4'h5,
    ST_RD_HIGH = 4'h6
  } host_state_e;

  typedef logic [2:0] step_t;
endpackage

// >>> core/seq_step_if.sv
// Purpose: carries a sequence-step lookup between host and table
// Assumes: table answers one cycle after the request
// Notes: none
`timescale 1ns/1ps
interface seq_step_if;
  flash_cmd_pkg::host_cmd_e cmd;
  flash_cmd_pkg::step_t step;
  logic [23:0] addr;
  logic [7:0] data;
  logic [23:0] wr_addr;
  logic [7:0] wr_data;
  logic last;
  modport req (output cmd, output step, output addr, output data,
               input wr_addr, input wr_data, input last);
  modport table_side (input cmd, input step, input addr, input data,
                      output wr_addr, output wr_data, output last);
endinterface

// >>> core/cmd_seq_rom.sv
// Purpose: bus-write sequence table for every flash command
// Assumes: byte mode unlock addresses
// Notes: output registered, one cycle latency
`timescale 1ns/1ps
`include "flash_cmd_cfg.svh"
module cmd_seq_rom (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  seq_step_if.table_side sq
);
  import flash_cmd_pkg::*;

  logic [23:0] bank_aaa;
  logic [23:0] nxt_addr;
  logic [7:0] nxt_data;
  logic nxt_last;

  assign bank_aaa = {sq.addr[23:`BANK_LSB], `UNLOCK1_ADDR};

  // steps 0..1 are the common unlock prefix where a command has one
  always_comb begin
    nxt_addr = {12'h000, `UNLOCK1_ADDR};
    nxt_data = `CODE_READ_RESET;
    nxt_last = 1'b1;
    unique case (sq.cmd)
      CMD_AUTO_SELECT, CMD_PROGRAM, CMD_CHIP_ERASE, CMD_BLOCK_ERASE: begin
        nxt_last = 1'b0;
        unique case (sq.step)
          3'd0, 3'd3: nxt_data = `CODE_UNLOCK1;
          3'd1, 3'd4: begin
            nxt_addr = {12'h000, `UNLOCK2_ADDR};
            nxt_data = `CODE_UNLOCK2;
          end
          3'd2: begin
            if (sq.cmd == CMD_AUTO_SELECT) begin
              nxt_addr = bank_aaa;
              nxt_data = `CODE_AUTO_SELECT;
              nxt_last = 1'b1;
            end else if (sq.cmd == CMD_PROGRAM) begin
              nxt_data = `CODE_PROGRAM;
            end else begin
              nxt_data = `CODE_ERASE_SETUP;
            end
          end
          default: begin
            nxt_last = 1'b1;
            if (sq.cmd == CMD_PROGRAM) begin
              nxt_addr = sq.addr;
              nxt_data = sq.data;
            end else if (sq.cmd == CMD_CHIP_ERASE) begin
              nxt_data = `CODE_CHIP_ERASE;
            end else begin
              nxt_addr = sq.addr;
              nxt_data = `CODE_BLOCK_ERASE;
            end
          end
        endcase
        if (sq.cmd == CMD_PROGRAM && sq.step == 3'd3) begin
          nxt_addr = sq.addr;
          nxt_data = sq.data;
          nxt_last = 1'b1;
        end
        if (sq.cmd != CMD_PROGRAM && sq.step != 3'd5 && sq.step > 3'd2) begin
          nxt_last = 1'b0;
        end
      end
      CMD_BLOCK_ADD: begin
        nxt_addr = sq.addr;
        nxt_data = `CODE_BLOCK_ERASE;
      end
      CMD_SUSPEND: begin
        nxt_addr = sq.addr;
        nxt_data = `CODE_SUSPEND;
      end
      CMD_RESUME: begin
        nxt_addr = sq.addr;
        nxt_data = `CODE_RESUME;
      end
      CMD_CFI_QUERY: begin
        nxt_addr = bank_aaa;
        nxt_data = `CODE_CFI_QUERY;
      end
      default: begin
        nxt_data = `CODE_READ_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sq.wr_addr <= 24'h00_0000;
      sq.wr_data <= 8'h00;
      sq.last <= 1'b1;
    end else begin
      sq.wr_addr <= nxt_addr;
      sq.wr_data <= nxt_data;
      sq.last <= nxt_last;
    end
  end
endmodule

// >>> core/flash_host_ctrl.sv
// Purpose: host-side command sequencer driving a parallel flash bus
// Assumes: byte mode, flash pins synchronous to core_clk_in
// Notes: one command at a time; dq split into in/out/enable
`timescale 1ns/1ps
`include "flash_cmd_cfg.svh"
module flash_host_ctrl #(
  parameter int unsigned POLL_LIMIT = `POLL_LIMIT_DEFAULT
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic cmd_valid_in,
  input wire flash_cmd_pkg::host_cmd_e cmd_in,
  input wire logic [23:0] cmd_addr_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic error_out,
  output logic [7:0] rd_data_out,
  output logic query_mode_out,
  output logic [23:0] flash_addr_out,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic flash_rst_n_out
);
  import flash_cmd_pkg::*;

  localparam logic [7:0] T_SETUP = 8'(`CYC_UP(`T_ADDR_SETUP_NS));
  localparam logic [7:0] T_WLOW = 8'(`CYC_UP(`T_WE_LOW_NS));
  localparam logic [7:0] T_WHIGH = 8'(`CYC_UP(`T_WE_HIGH_NS));
  localparam logic [7:0] T_RACC = 8'(`CYC_UP(`T_READ_ACC_NS));
  localparam logic [7:0] T_RREC = 8'(`CYC_UP(`T_READ_REC_NS));
  localparam logic [31:0] POLL_MAX = 32'(POLL_LIMIT);

  seq_step_if sq ();

  host_state_e state_ff;
  host_cmd_e cmd_ff;
  step_t step_ff;
  logic [7:0] tmr_ff;
  logic [23:0] addr_ff;
  logic [7:0] data_ff;
  logic polling_ff;
  logic poll_first_ff;
  logic [7:0] prev_rd_ff;
  logic [31:0] poll_cnt_ff;
  logic pending_resume_ff;
  logic timer_done;
  logic toggle_still;
  logic poll_timeout;
  logic finish;

  function automatic logic is_query_entry(input host_cmd_e c);
    return (c == CMD_AUTO_SELECT) || (c == CMD_CFI_QUERY);
  endfunction

  assign sq.cmd = cmd_ff;
  assign sq.step = step_ff;
  assign sq.addr = addr_ff;
  assign sq.data = data_ff;

  cmd_seq_rom u_rom (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .sq(sq)
  );

  assign timer_done = (tmr_ff == 8'h00);
  // compare the last two registered reads; the pin itself is released by now
  assign toggle_still = (prev_rd_ff[`TOGGLE_BIT] == rd_data_out[`TOGGLE_BIT]);
  assign poll_timeout = (poll_cnt_ff >= POLL_MAX);
  assign finish = (state_ff == ST_RD_HIGH && timer_done &&
                   (!polling_ff || (!poll_first_ff && toggle_still) ||
                    poll_timeout)) ||
                  (state_ff == ST_WE_HIGH && timer_done && sq.last &&
                   cmd_ff != CMD_PROGRAM);

  // sequencing and pin drive
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= ST_IDLE;
      cmd_ff <= CMD_READ_RESET;
      step_ff <= 3'd0;
      tmr_ff <= 8'h00;
      addr_ff <= 24'h00_0000;
      data_ff <= 8'h00;
      cmd_ready_out <= 1'b0;
      flash_addr_out <= 24'h00_0000;
      flash_dq_out <= 8'h00;
      flash_dq_oe_out <= 1'b0;
      flash_ce_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_rst_n_out <= 1'b0;
      polling_ff <= 1'b0;
      poll_first_ff <= 1'b0;
      pending_resume_ff <= 1'b0;
    end else begin
      flash_rst_n_out <= 1'b1;
      if (tmr_ff != 8'h00) begin
        tmr_ff <= tmr_ff - 8'h01;
      end
      unique case (state_ff)
        ST_IDLE: begin
          cmd_ready_out <= !pending_resume_ff;
          if (pending_resume_ff) begin
            // no extra-block entry is ever issued, so no exit is owed first
            cmd_ff <= CMD_RESUME;
            pending_resume_ff <= 1'b0;
            step_ff <= 3'd0;
            state_ff <= ST_LOOK;
          end else if (cmd_valid_in && cmd_ready_out) begin
            cmd_ready_out <= 1'b0;
            addr_ff <= cmd_addr_in;
            data_ff <= cmd_data_in;
            step_ff <= 3'd0;
            polling_ff <= (cmd_in == CMD_POLL);
            poll_first_ff <= 1'b1;
            if (cmd_in == CMD_READ || cmd_in == CMD_POLL) begin
              cmd_ff <= cmd_in;
              flash_addr_out <= cmd_addr_in;
              flash_ce_n_out <= 1'b0;
              flash_oe_n_out <= 1'b0;
              tmr_ff <= T_RACC;
              state_ff <= ST_RD_LOW;
            end else if (cmd_in == CMD_RESUME && query_mode_out) begin
              // resume is only taken in array read mode
              cmd_ff <= CMD_READ_RESET;
              pending_resume_ff <= 1'b1;
              state_ff <= ST_LOOK;
            end else begin
              cmd_ff <= cmd_in;
              state_ff <= ST_LOOK;
            end
          end
        end
        ST_LOOK: begin
          state_ff <= ST_SETUP;
        end
        ST_SETUP: begin
          flash_addr_out <= sq.wr_addr;
          flash_dq_out <= sq.wr_data;
          flash_dq_oe_out <= 1'b1;
          flash_ce_n_out <= 1'b0;
          tmr_ff <= T_SETUP;
          state_ff <= ST_WE_LOW;
        end
        ST_WE_LOW: begin
          if (timer_done && flash_we_n_out) begin
            flash_we_n_out <= 1'b0;
            tmr_ff <= T_WLOW;
          end else if (timer_done) begin
            flash_we_n_out <= 1'b1; // data latched on rising edge
            tmr_ff <= T_WHIGH;
            state_ff <= ST_WE_HIGH;
          end
        end
        ST_WE_HIGH: begin
          flash_ce_n_out <= 1'b1;
          if (timer_done) begin
            flash_dq_oe_out <= 1'b0;
            if (!sq.last) begin
              step_ff <= step_ff + 3'd1;
              state_ff <= ST_LOOK;
            end else if (cmd_ff == CMD_PROGRAM) begin
              // poll the target address until the toggle bit settles
              polling_ff <= 1'b1;
              poll_first_ff <= 1'b1;
              flash_addr_out <= addr_ff;
              flash_ce_n_out <= 1'b0;
              flash_oe_n_out <= 1'b0;
              tmr_ff <= T_RACC;
              state_ff <= ST_RD_LOW;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_RD_LOW: begin
          if (timer_done) begin
            flash_ce_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            tmr_ff <= T_RREC;
            state_ff <= ST_RD_HIGH;
          end
        end
        ST_RD_HIGH: begin
          if (timer_done) begin
            if (polling_ff && poll_timeout) begin
              // stuck or failed operation: clear it with read/reset
              polling_ff <= 1'b0;
              cmd_ff <= CMD_READ_RESET;
              step_ff <= 3'd0;
              state_ff <= ST_LOOK;
            end else if (finish) begin
              state_ff <= ST_IDLE;
            end else begin
              poll_first_ff <= 1'b0;
              flash_ce_n_out <= 1'b0;
              flash_oe_n_out <= 1'b0;
              tmr_ff <= T_RACC;
              state_ff <= ST_RD_LOW;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // read results, poll bookkeeping, mode tracking
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= 8'h00;
      prev_rd_ff <= 8'h00;
      poll_cnt_ff <= 32'h0000_0000;
      done_out <= 1'b0;
      error_out <= 1'b0;
      query_mode_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (state_ff == ST_RD_LOW && timer_done) begin
        rd_data_out <= flash_dq_in;
        prev_rd_ff <= rd_data_out;
      end
      if (state_ff == ST_IDLE) begin
        poll_cnt_ff <= 32'h0000_0000;
      end else if (state_ff == ST_RD_HIGH && timer_done && polling_ff) begin
        poll_cnt_ff <= poll_cnt_ff + 32'h0000_0001;
      end
      if (state_ff == ST_RD_HIGH && timer_done && polling_ff && poll_timeout) begin
        error_out <= 1'b1;
      end else if (state_ff == ST_IDLE && cmd_valid_in && cmd_ready_out) begin
        error_out <= 1'b0;
      end
      if (state_ff == ST_WE_HIGH && timer_done && sq.last) begin
        if (is_query_entry(cmd_ff)) begin
          query_mode_out <= 1'b1;
        end else if (cmd_ff == CMD_READ_RESET) begin
          query_mode_out <= 1'b0;
        end
      end
      if (finish && !pending_resume_ff &&
          !(polling_ff && poll_timeout)) begin
        done_out <= 1'b1;
      end else if (state_ff == ST_WE_HIGH && timer_done && sq.last &&
                   cmd_ff == CMD_READ_RESET && error_out) begin
        done_out <= 1'b1;
      end
    end
  end
endmodule

// >>> verification/flash_host_ctrl_properties.sv
// Purpose: bus-level checks on the flash command host
// Assumes: flash pins registered on core_clk_in
// Notes: bound to every flash_host_ctrl instance
`timescale 1ns/1ps
`include "flash_cmd_cfg.svh"
module flash_host_ctrl_properties #(
  parameter int unsigned POLL_LIMIT = `POLL_LIMIT_DEFAULT
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic done_out,
  input wire logic error_out,
  input wire logic [23:0] flash_addr_out,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_we_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_rst_n_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_accept;
    cmd_valid_in && cmd_ready_out;
  endsequence
  // write strobe must cover the device's minimum low time
  sequence s_we_low;
    (!flash_we_n_out && !flash_ce_n_out)[*7];
  endsequence
  sequence s_read_low;
    (!flash_oe_n_out && !flash_ce_n_out)[*8];
  endsequence
  chk_we_width: assert property ($fell(flash_we_n_out) |-> s_we_low)
    else $error("write strobe too short");
  chk_write_drive: assert property (!flash_we_n_out |-> flash_dq_oe_out && flash_oe_n_out)
    else $error("write without driven data");
  chk_write_stable: assert property (!flash_we_n_out && $past(!flash_we_n_out)
    |-> $stable(flash_addr_out) && $stable(flash_dq_out))
    else $error("address or data moved during write");
  chk_no_contention: assert property (!flash_oe_n_out |-> !flash_dq_oe_out)
    else $error("host drives dq during read");
  chk_read_width: assert property ($fell(flash_oe_n_out) |-> s_read_low)
    else $error("read strobe too short");
  chk_accept_busy: assert property (s_accept |=> !cmd_ready_out && !error_out)
    else $error("accept did not clear ready or error");
  chk_done_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  chk_ready_quiet: assert property (cmd_ready_out
    |-> flash_ce_n_out && flash_we_n_out && flash_oe_n_out)
    else $error("bus active while ready");
  chk_error_done: assert property ($rose(error_out) |-> ##[1:200] done_out)
    else $error("no completion after poll timeout");
  chk_flash_rst: assert property ($past(arst_n_in) |-> flash_rst_n_out)
    else $error("flash reset held after release");
endmodule

bind flash_host_ctrl flash_host_ctrl_properties #(.POLL_LIMIT(POLL_LIMIT)) chk_inst (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid_in),
  .cmd_ready_out(cmd_ready_out), .done_out(done_out), .error_out(error_out),
  .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_out(flash_dq_oe_out), .flash_ce_n_out(flash_ce_n_out),
  .flash_we_n_out(flash_we_n_out), .flash_oe_n_out(flash_oe_n_out),
  .flash_rst_n_out(flash_rst_n_out));

// >>> verification/flash_dev_model.sv
// Purpose: behavioural byte-mode flash facing the host sequencer
// Assumes: writes latched on we rise with ce low
// Notes: 16-byte array; busy time counted in status reads, not ns
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int BUSY_READS = 3
) (
  input wire logic [23:0] addr_in,
  input wire logic [7:0] dq_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic rst_n_in,
  input wire logic stuck_in,
  output logic [7:0] dq_out,
  output logic dq_en_out,
  output logic [5:0][11:0] log_a_out = '0,
  output logic [5:0][7:0] log_d_out = '0
);
  logic [7:0] mem [0:15];
  int busy = 0;
  logic chip = 1'b0;
  logic susp = 1'b0;
  logic tog = 1'b0;
  logic query = 1'b0;
  logic st_rd = 1'b0;
  logic [11:0] bank = 12'h000;
  logic [7:0] prog_val = 8'h00;
  wire in_bank = busy != 0 && addr_in[23:12] == bank;
  // outside query mode, busy or suspended bank shows status, other banks array data
  assign dq_out = query ? 8'h01 : in_bank ? {~prog_val[7], tog, 6'h00} : mem[addr_in[3:0]];
  assign dq_en_out = rst_n_in === 1'b1 && !ce_n_in && !oe_n_in;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
  end
  always @(negedge rst_n_in) begin
    busy = 0;
    susp = 1'b0;
    query = 1'b0;
  end
  always @(negedge oe_n_in) st_rd = in_bank && !susp;
  always @(posedge oe_n_in) begin
    if (rst_n_in === 1'b1 && st_rd) begin
      tog = !tog;
      if (!stuck_in) busy = busy - 1;
    end
  end
  always @(posedge we_n_in) begin
    if (rst_n_in === 1'b1 && ce_n_in === 1'b0) begin
      log_a_out = {log_a_out[4:0], addr_in[11:0]};
      log_d_out = {log_d_out[4:0], dq_in};
      if (dq_in == 8'hF0) begin
        query = 1'b0;
        if (stuck_in) busy = 0;
      end else if ({log_d_out[3], log_d_out[2], log_d_out[1]} == 24'hAA55_A0) begin
        if (!(susp && addr_in[23:12] == bank)) begin
          mem[addr_in[3:0]] = mem[addr_in[3:0]] & dq_in;
          busy = BUSY_READS;
          chip = 1'b0;
          bank = addr_in[23:12];
          prog_val = dq_in;
        end
      end else if (log_d_out[5:1] == 40'hAA55_80AA_55) begin
        for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
        busy = BUSY_READS;
        chip = dq_in == 8'h10;
        bank = addr_in[23:12];
      end else if (dq_in == 8'hB0 && busy != 0 && !chip) begin
        susp = 1'b1;
      end else if (dq_in == 8'h30 && susp && !query) begin
        susp = 1'b0;
      end else if (dq_in == 8'h30 && busy != 0 && !chip && !susp) begin
        busy = BUSY_READS;
      end else if (dq_in == 8'h98 || dq_in == 8'h90) begin
        query = 1'b1;
      end
    end
  end
endmodule

// >>> verification/testbench.sv
// Purpose: self-checking bench for the flash command host
// Assumes: poll limit shortened to 8
// Notes: dq resolved here from host and device enables
`timescale 1ns/1ps
module testbench;
  import flash_cmd_pkg::*;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cmd_valid = 1'b0;
  host_cmd_e cmd = CMD_READ;
  logic [23:0] cmd_addr = 24'h00_0000;
  logic [7:0] cmd_data = 8'h00;
  logic ready, done, error, query, dq_oe, ce_n, we_n, oe_n, f_rst_n, dev_en;
  logic stuck = 1'b0;
  logic [7:0] rd_data, host_dq, dev_dq, dq_wire;
  logic [7:0] dq_last = 8'h00;
  logic [23:0] f_addr;
  logic [5:0][11:0] log_a;
  logic [5:0][7:0] log_d;
  logic [19:0] pre [0:4] = '{20'hA_AAAA, 20'h5_5555, 20'hA_AA80, 20'hA_AAAA, 20'h5_5555};
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // released bus shows inverted last value, never a settled guess
  assign dq_wire = dev_en ? dev_dq : dq_oe ? host_dq : ~dq_last;
  always @(posedge core_clk_in) if (dev_en || dq_oe) dq_last <= dq_wire;
  always #2.5 core_clk_in = ~core_clk_in;
  flash_host_ctrl #(.POLL_LIMIT(8)) flash_host_ctrl_inst (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_addr_in(cmd_addr),
    .cmd_data_in(cmd_data), .cmd_ready_out(ready), .done_out(done), .error_out(error),
    .rd_data_out(rd_data), .query_mode_out(query), .flash_addr_out(f_addr),
    .flash_dq_out(host_dq), .flash_dq_oe_out(dq_oe), .flash_dq_in(dq_wire),
    .flash_ce_n_out(ce_n), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n),
    .flash_rst_n_out(f_rst_n));
  flash_dev_model flash_dev_model_inst (.addr_in(f_addr), .dq_in(host_dq), .ce_n_in(ce_n),
    .we_n_in(we_n), .oe_n_in(oe_n), .rst_n_in(f_rst_n), .stuck_in(stuck), .dq_out(dev_dq),
    .dq_en_out(dev_en), .log_a_out(log_a), .log_d_out(log_d));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_wr(input int i, input logic [19:0] exp);
    num_checks++;
    if ({log_a[i], log_d[i]} !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, {log_a[i], log_d[i]}, exp);
    end
  endtask
  task automatic run(input host_cmd_e c, input logic [23:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge core_clk_in);
    cmd_valid = 1'b1;
    cmd = c;
    cmd_addr = a;
    cmd_data = d;
    while (ready !== 1'b1) @(negedge core_clk_in);
    @(negedge core_clk_in);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge core_clk_in);
      n++;
    end
    chk({7'h00, done}, 8'h01);
  endtask
  task automatic t_program;
    run(CMD_PROGRAM, 24'h00_1003, 8'h5A);
    for (int i = 0; i < 3; i++) chk_wr(3 - i, pre[i] ^ {12'h000, (i == 2) ? 8'h20 : 8'h00});
    chk_wr(0, 20'h0_035A);
    run(CMD_READ, 24'h00_1003, 8'h00);
    chk(rd_data, 8'h5A);
    run(CMD_PROGRAM, 24'h00_1003, 8'h0F);
    run(CMD_READ, 24'h00_1003, 8'h00);
    chk(rd_data, 8'h0A);
    chk({7'h00, error}, 8'h00);
    $display("test program finished");
  endtask
  task automatic t_chip;
    run(CMD_CHIP_ERASE, 24'h00_0000, 8'h00);
    for (int i = 0; i < 5; i++) chk_wr(5 - i, pre[i]);
    chk_wr(0, 20'hA_AA10);
    run(CMD_SUSPEND, 24'h00_0000, 8'h00);
    chk_wr(0, 20'h0_00B0);
    run(CMD_POLL, 24'h00_0000, 8'h00);
    run(CMD_READ, 24'h00_1005, 8'h00);
    chk(rd_data, 8'hFF);
    $display("test chip erase finished");
  endtask
  task automatic t_block;
    run(CMD_BLOCK_ERASE, 24'h00_2040, 8'h00);
    chk_wr(1, 20'h5_5555);
    chk_wr(0, 20'h0_4030);
    run(CMD_BLOCK_ADD, 24'h00_2080, 8'h00);
    chk_wr(0, 20'h0_8030);
    run(CMD_SUSPEND, 24'h00_2000, 8'h00);
    chk_wr(0, 20'h0_00B0);
    run(CMD_AUTO_SELECT, 24'h00_2000, 8'h00);
    chk({7'h00, query}, 8'h01);
    chk(log_d[0], 8'h90);
    run(CMD_RESUME, 24'h00_2000, 8'h00);
    chk(log_d[1], 8'hF0);
    chk_wr(0, 20'h0_0030);
    chk({7'h00, query}, 8'h00);
    run(CMD_SUSPEND, 24'h00_2000, 8'h00);
    run(CMD_RESUME, 24'h00_2000, 8'h00);
    chk(log_d[1], 8'hB0);
    chk_wr(0, 20'h0_0030);
    run(CMD_POLL, 24'h00_2000, 8'h00);
    run(CMD_READ, 24'h00_2040, 8'h00);
    chk(rd_data, 8'hFF);
    $display("test block erase finished");
  endtask
  task automatic t_timeout;
    stuck = 1'b1;
    run(CMD_PROGRAM, 24'h00_3001, 8'h33);
    chk({7'h00, error}, 8'h01);
    chk(log_d[0], 8'hF0);
    stuck = 1'b0;
    run(CMD_CFI_QUERY, 24'h00_1000, 8'h00);
    chk({7'h00, error}, 8'h00);
    chk(log_d[0], 8'h98);
    chk({7'h00, query}, 8'h01);
    run(CMD_READ_RESET, 24'h00_1000, 8'h00);
    chk(log_d[0], 8'hF0);
    chk({7'h00, query}, 8'h00);
    run(CMD_READ, 24'h00_3001, 8'h00);
    chk(rd_data, 8'h33);
    $display("test timeout and query finished");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // whole run needs under two thousand cycles; ceiling leaves wide margin
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(negedge core_clk_in);
    arst_n_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    t_program();
    t_chip();
    t_block();
    t_timeout();
    wrap_up();
  end
endmodule
